// >>> src/nvp_fifo.sv
// Job queue between command decode and the pulse engine
`timescale 1ns/1ns
module nvp_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] rdPtr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   assign inReady = count_ff != (AW+1)'(DEPTH);
   assign outValid = count_ff != '0;
   assign outData = mem[rdPtr_ff];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   // Depth is a power of two, so pointers wrap on their own
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
      end else begin
         if (push) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
         end
         if (pop) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_ff <= '0;
      end else if (push && !pop) begin
         count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
         count_ff <= count_ff - 1'b1;
      end
   end
endmodule

// >>> src/nvp_map.svh
// Offsets, encodings and timing counts of the nonvolatile programming sequencer
`ifndef NVP_MAP_SVH
`define NVP_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define NVP_CLK_HZ 20000000
`define NVP_CYC_PER_US (`NVP_CLK_HZ / 1000000)
`define NVP_ENTER_MS 1
`define NVP_EXIT_MS 1
`define NVP_ERASE_MS 100
`define NVP_PROG_PULSE_US 10
`define NVP_READ_PULSE_NS 200
`define NVP_ENTER_CYC (`NVP_ENTER_MS * 1000 * `NVP_CYC_PER_US)
`define NVP_EXIT_CYC (`NVP_EXIT_MS * 1000 * `NVP_CYC_PER_US)
`define NVP_ERASE_CYC (`NVP_ERASE_MS * 1000 * `NVP_CYC_PER_US)
`define NVP_PROG_CYC (`NVP_PROG_PULSE_US * `NVP_CYC_PER_US)
`define NVP_READ_CYC ((`NVP_READ_PULSE_NS * `NVP_CYC_PER_US + 999) / 1000)

// ----------------------------------------------------------------------
// Command opcodes and frame lengths
// ----------------------------------------------------------------------
`define NVP_OP_ENTER 8'h01
`define NVP_OP_IDCODE 8'h02
`define NVP_OP_ERASE 8'h03
`define NVP_OP_PROGRAM 8'h04
`define NVP_OP_VERIFY 8'h05
`define NVP_OP_EXIT 8'h06
`define NVP_LEN_SHORT 6'h08
`define NVP_LEN_ADDR 6'h10
`define NVP_LEN_WORD 6'h20

// ----------------------------------------------------------------------
// Widths and values
// ----------------------------------------------------------------------
`define NVP_ADDR_W 8
`define NVP_DATA_W 16
`define NVP_ENTRY_W 26
`define NVP_FIFO_DEPTH 32
`define NVP_TIMER_W 21
`define NVP_ERASED 16'hffff
// Arbitrary identity value
`define NVP_ID_CODE 16'h5a3c

`endif

// >>> src/nvp_pkg.sv
// Types of the nonvolatile programming sequencer
package nvp_pkg;
   typedef enum logic [2:0] {
      ST_USER = 3'b000,
      ST_ENTER = 3'b001,
      ST_READY = 3'b010,
      ST_ERASE = 3'b011,
      ST_PROG = 3'b100,
      ST_READ = 3'b101,
      ST_EXIT = 3'b110
   } nvp_state_t;

   typedef enum logic [1:0] {
      JOB_ERASE = 2'b00,
      JOB_PROG = 2'b01,
      JOB_READ = 2'b10
   } nvp_job_t;
endpackage

// >>> src/nvp_program_seq.sv
// Nonvolatile cell programming sequencer behind the serial test port
//
// Behaviour
// R1 - Commands in on tdi, readback out on tdo
// R2 - Programmer compares readback against expected pattern
// R3 - Full run: enter, id, erase, program, verify, exit
// R4 - Verify-only run skips erase and program
// R5 - Enter moves pins glitch-free, 1 ms settle
// R6 - Programmer checks identity before program or verify
// R7 - Erase applies one 100 ms pulse
// R8 - Each address: shift address, data, program pulse
// R9 - Each address: shift address, read pulse, readback
// R10 - Exit returns pins glitch-free, 1 ms settle
// R11 - Accept the standard command set and flow
// R12 - Programmer stops on identity mismatch; bench skips only the verify-only run's verify, full run goes on to erase
`timescale 1ns/1ns
`include "nvp_map.svh"
module nvp_program_seq #(
   parameter int ENTER_CYC = `NVP_ENTER_CYC,
   parameter int EXIT_CYC = `NVP_EXIT_CYC,
   parameter int ERASE_CYC = `NVP_ERASE_CYC
) (
   // System clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial test port, link clock domain
   input wire logic tck,
   input wire logic tsel,
   input wire logic tdi,
   output logic tdoOut,
   output logic tdoEn,
   // Pin mode and status
   output logic ioProgMode,
   output logic progReady,
   output logic userReady,
   output logic seqBusy,
   output logic frameError
);
   localparam int PROG_CYC = `NVP_PROG_CYC;
   localparam int READ_CYC = `NVP_READ_CYC;
   localparam int AW = `NVP_ADDR_W;
   localparam int DW = `NVP_DATA_W;
   localparam int TW = `NVP_TIMER_W;

   // ----------------------------------------------------------------------
   // Link domain: shift in, shift out
   // ----------------------------------------------------------------------
   logic [31:0] linkSh_ff;
   logic [5:0] linkCnt_ff;
   logic tselLast_ff;
   logic [DW-1:0] tdoSh_ff;
   logic tdoOut_ff;
   logic tdoEn_ff;
   logic [DW-1:0] readWord_ff;

   // Counter restarts on the first high edge; low edges leave the frame intact
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         linkSh_ff <= '0;
         linkCnt_ff <= '0;
         tselLast_ff <= 1'b0;
      end else begin
         tselLast_ff <= tsel;
         if (tsel) begin
            linkSh_ff <= {linkSh_ff[30:0], tdi}; // [R1]
            if (!tselLast_ff) begin
               linkCnt_ff <= 6'h01;
            end else if (linkCnt_ff != 6'h3f) begin
               linkCnt_ff <= linkCnt_ff + 6'h01;
            end
         end
      end
   end

   // Readback is held still between frames, so it is safe to load here
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         tdoSh_ff <= '0;
         tdoOut_ff <= 1'b0;
         tdoEn_ff <= 1'b0;
      end else begin
         tdoEn_ff <= tsel;
         if (tsel && !tselLast_ff) begin
            tdoOut_ff <= readWord_ff[DW-1]; // [R1]
            tdoSh_ff <= {readWord_ff[DW-2:0], 1'b0};
         end else if (tsel) begin
            tdoOut_ff <= tdoSh_ff[DW-1]; // [R1]
            tdoSh_ff <= {tdoSh_ff[DW-2:0], 1'b0};
         end
      end
   end

   assign tdoOut = tdoOut_ff;
   assign tdoEn = tdoEn_ff;

   // ----------------------------------------------------------------------
   // Frame end detection and decode
   // ----------------------------------------------------------------------
   logic selMeta_ff;
   logic selSync_ff;
   logic selLast_ff;
   logic frameEnd;
   logic [7:0] candOp;
   logic [AW-1:0] candAddr;
   logic [DW-1:0] candData;
   logic frameOk;
   logic candJob;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         selMeta_ff <= 1'b0;
         selSync_ff <= 1'b0;
         selLast_ff <= 1'b0;
      end else begin
         selMeta_ff <= tsel;
         selSync_ff <= selMeta_ff;
         selLast_ff <= selSync_ff;
      end
   end

   assign frameEnd = selLast_ff && !selSync_ff;

   always_comb begin
      candOp = 8'h00;
      candAddr = '0;
      candData = '0;
      frameOk = 1'b0;
      case (linkCnt_ff)
         `NVP_LEN_SHORT: begin
            candOp = linkSh_ff[7:0];
            frameOk = candOp == `NVP_OP_ENTER || candOp == `NVP_OP_IDCODE ||
               candOp == `NVP_OP_ERASE || candOp == `NVP_OP_EXIT; // [R11]
         end
         `NVP_LEN_ADDR: begin
            candOp = linkSh_ff[15:8];
            candAddr = linkSh_ff[7:0];
            frameOk = candOp == `NVP_OP_VERIFY; // [R11]
         end
         `NVP_LEN_WORD: begin
            candOp = linkSh_ff[31:24];
            candAddr = linkSh_ff[23:16];
            candData = linkSh_ff[15:0];
            frameOk = candOp == `NVP_OP_PROGRAM; // [R11]
         end
         default: begin
            frameOk = 1'b0;
         end
      endcase
      candJob = candOp == `NVP_OP_ERASE || candOp == `NVP_OP_PROGRAM ||
         candOp == `NVP_OP_VERIFY;
   end

   // ----------------------------------------------------------------------
   // Pending command
   // ----------------------------------------------------------------------
   nvp_pkg::nvp_state_t state_ff;
   logic pendValid_ff;
   logic [7:0] pendOp_ff;
   logic [AW-1:0] pendAddr_ff;
   logic [DW-1:0] pendData_ff;
   logic progReady_ff;
   logic ioProgMode_ff;
   logic frameError_ff;
   logic pendJob;
   logic pendDone;
   logic enterGo;
   logic exitGo;
   logic fifoInValid;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoPop;
   logic [`NVP_ENTRY_W-1:0] fifoOutData;
   nvp_pkg::nvp_job_t pendJobCode;

   always_comb begin
      pendJob = pendOp_ff == `NVP_OP_ERASE || pendOp_ff == `NVP_OP_PROGRAM ||
         pendOp_ff == `NVP_OP_VERIFY;
      pendJobCode = nvp_pkg::JOB_ERASE;
      if (pendOp_ff == `NVP_OP_PROGRAM) begin
         pendJobCode = nvp_pkg::JOB_PROG;
      end else if (pendOp_ff == `NVP_OP_VERIFY) begin
         pendJobCode = nvp_pkg::JOB_READ;
      end
      enterGo = pendValid_ff && pendOp_ff == `NVP_OP_ENTER && state_ff == nvp_pkg::ST_USER;
      // Exit waits for queued jobs so no pulse is cut short
      exitGo = pendValid_ff && pendOp_ff == `NVP_OP_EXIT &&
         state_ff == nvp_pkg::ST_READY && !fifoOutValid; // [R10]
      fifoInValid = pendValid_ff && pendJob && progReady_ff; // [R11]
      pendDone = 1'b0;
      if (pendValid_ff) begin
         if (pendJob) begin
            pendDone = !progReady_ff || fifoInReady;
         end else if (pendOp_ff == `NVP_OP_EXIT) begin
            pendDone = exitGo || state_ff == nvp_pkg::ST_USER;
         end else begin
            pendDone = 1'b1;
         end
      end
   end

   // A frame that lands while one is still pending is dropped
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pendValid_ff <= 1'b0;
         pendOp_ff <= 8'h00;
         pendAddr_ff <= '0;
         pendData_ff <= '0;
      end else if (frameEnd && frameOk && !pendValid_ff) begin
         pendValid_ff <= 1'b1;
         pendOp_ff <= candOp;
         pendAddr_ff <= candAddr;
         pendData_ff <= candData;
      end else if (pendDone) begin
         pendValid_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         frameError_ff <= 1'b0;
      end else if (frameEnd) begin
         frameError_ff <= !frameOk || pendValid_ff || (candJob && !progReady_ff);
      end
   end

   nvp_fifo #(
      .WIDTH(`NVP_ENTRY_W),
      .DEPTH(`NVP_FIFO_DEPTH)
   ) u_jobs (
      .clk(clk),
      .nrst(nrst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData({pendJobCode, pendAddr_ff, pendData_ff}),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOutData)
   );

   // ----------------------------------------------------------------------
   // Mode and pulse sequencing
   // ----------------------------------------------------------------------
   logic [TW-1:0] timer_ff;
   logic userReady_ff;
   logic erasePulse_ff;
   logic progPulse_ff;
   logic readPulse_ff;
   logic [AW-1:0] engAddr_ff;
   logic [DW-1:0] engData_ff;
   logic pulseDone;
   nvp_pkg::nvp_job_t popJob;

   assign fifoPop = state_ff == nvp_pkg::ST_READY && fifoOutValid;
   assign popJob = nvp_pkg::nvp_job_t'(fifoOutData[`NVP_ENTRY_W-1:AW+DW]);
   assign pulseDone = (state_ff == nvp_pkg::ST_ERASE || state_ff == nvp_pkg::ST_PROG ||
      state_ff == nvp_pkg::ST_READ) && timer_ff == '0;

   // Pin mode flips from one flop, so the pins see a single clean edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= nvp_pkg::ST_USER;
         timer_ff <= '0;
         ioProgMode_ff <= 1'b0;
         progReady_ff <= 1'b0;
         userReady_ff <= 1'b1;
         erasePulse_ff <= 1'b0;
         progPulse_ff <= 1'b0;
         readPulse_ff <= 1'b0;
      end else begin
         case (state_ff)
            nvp_pkg::ST_USER: begin
               if (enterGo) begin
                  state_ff <= nvp_pkg::ST_ENTER;
                  ioProgMode_ff <= 1'b1; // [R5]
                  userReady_ff <= 1'b0;
                  timer_ff <= TW'(ENTER_CYC - 1); // [R5]
               end
            end
            nvp_pkg::ST_ENTER, nvp_pkg::ST_EXIT: begin
               if (timer_ff != '0) begin
                  timer_ff <= timer_ff - 1'b1;
               end else if (state_ff == nvp_pkg::ST_ENTER) begin
                  state_ff <= nvp_pkg::ST_READY;
                  progReady_ff <= 1'b1; // [R5]
               end else begin
                  state_ff <= nvp_pkg::ST_USER;
                  userReady_ff <= 1'b1; // [R10]
               end
            end
            nvp_pkg::ST_READY: begin
               if (fifoPop) begin
                  case (popJob)
                     nvp_pkg::JOB_ERASE: begin
                        state_ff <= nvp_pkg::ST_ERASE;
                        erasePulse_ff <= 1'b1;
                        timer_ff <= TW'(ERASE_CYC - 1); // [R7]
                     end
                     nvp_pkg::JOB_PROG: begin
                        state_ff <= nvp_pkg::ST_PROG;
                        progPulse_ff <= 1'b1;
                        timer_ff <= TW'(PROG_CYC - 1); // [R8]
                     end
                     default: begin
                        state_ff <= nvp_pkg::ST_READ;
                        readPulse_ff <= 1'b1;
                        timer_ff <= TW'(READ_CYC - 1); // [R9]
                     end
                  endcase
               end else if (exitGo) begin
                  state_ff <= nvp_pkg::ST_EXIT;
                  ioProgMode_ff <= 1'b0; // [R10]
                  progReady_ff <= 1'b0;
                  timer_ff <= TW'(EXIT_CYC - 1); // [R10]
               end
            end
            nvp_pkg::ST_ERASE, nvp_pkg::ST_PROG, nvp_pkg::ST_READ: begin
               if (timer_ff == '0) begin
                  state_ff <= nvp_pkg::ST_READY;
                  erasePulse_ff <= 1'b0;
                  progPulse_ff <= 1'b0;
                  readPulse_ff <= 1'b0;
               end else begin
                  timer_ff <= timer_ff - 1'b1;
               end
            end
            default: begin
               state_ff <= nvp_pkg::ST_USER;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         engAddr_ff <= '0;
         engData_ff <= '0;
      end else if (fifoPop) begin
         engAddr_ff <= fifoOutData[AW+DW-1:DW];
         engData_ff <= fifoOutData[DW-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Nonvolatile cells and readback
   // ----------------------------------------------------------------------
   logic [DW-1:0] cells [2**AW];
   logic [DW-1:0] cellWord;

   assign cellWord = cells[engAddr_ff];

   // Cells change only as a pulse completes, never part way through
   always_ff @(posedge clk) begin
      if (pulseDone && state_ff == nvp_pkg::ST_ERASE) begin
         for (int i = 0; i < 2**AW; i++) begin
            cells[i] <= `NVP_ERASED; // [R7]
         end
      end else if (pulseDone && state_ff == nvp_pkg::ST_PROG) begin
         cells[engAddr_ff] <= engData_ff; // [R8]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         readWord_ff <= '0;
      end else if (pulseDone && state_ff == nvp_pkg::ST_READ) begin
         readWord_ff <= cellWord; // [R9]
      end else if (pendValid_ff && pendOp_ff == `NVP_OP_IDCODE && progReady_ff) begin
         readWord_ff <= `NVP_ID_CODE;
      end
   end

   logic seqBusy_ff;

   // Busy tells the programmer when readback is final and a frame is welcome
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         seqBusy_ff <= 1'b0;
      end else begin
         seqBusy_ff <= pendValid_ff || fifoOutValid || state_ff == nvp_pkg::ST_ENTER ||
            state_ff == nvp_pkg::ST_EXIT || pulseDone || erasePulse_ff || progPulse_ff ||
            readPulse_ff;
      end
   end

   assign ioProgMode = ioProgMode_ff;
   assign progReady = progReady_ff;
   assign userReady = userReady_ff;
   assign seqBusy = seqBusy_ff;
   assign frameError = frameError_ff;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   nvp_pkg::nvp_state_t stateLast_ff;
   logic [TW:0] phaseLen_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stateLast_ff <= nvp_pkg::ST_USER;
         phaseLen_ff <= '0;
      end else begin
         stateLast_ff <= state_ff;
         phaseLen_ff <= (state_ff != stateLast_ff) ? (TW+1)'(1) : phaseLen_ff + 1'b1;
      end
   end

   sequence sqExitBegin;
      $fell(ioProgMode_ff);
   endsequence

   sequence sqPinsHeld;
      !userReady_ff [*2];
   endsequence

   sequence sqReadPulse;
      readPulse_ff [*4] ##1 !readPulse_ff;
   endsequence

   AST_TDI_SHIFT: assert property (@(posedge tck) disable iff (!nrst) // [R1]
      tsel |=> linkSh_ff[0] == $past(tdi))
      else $error("tdi bit not shifted in");
   AST_TDO_SHIFT: assert property (@(posedge tck) disable iff (!nrst) // [R1]
      tsel && tselLast_ff |=> tdoOut_ff == $past(tdoSh_ff[DW-1]))
      else $error("tdo not fed from readback shift");
   AST_ENTER_SETTLE: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      $rose(progReady_ff) |-> phaseLen_ff == (TW+1)'(ENTER_CYC) && ioProgMode_ff)
      else $error("enter settle time wrong");
   AST_PIN_CLEAN: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      $changed(ioProgMode_ff) |-> $past(state_ff) == nvp_pkg::ST_USER ||
         $past(state_ff) == nvp_pkg::ST_READY)
      else $error("pin mode moved outside enter or exit");
   AST_ERASE_LEN: assert property (@(posedge clk) disable iff (!nrst) // [R7]
      $fell(erasePulse_ff) |-> phaseLen_ff == (TW+1)'(ERASE_CYC) && cells[0] == `NVP_ERASED)
      else $error("erase pulse length or result wrong");
   AST_PROG_PULSE: assert property (@(posedge clk) disable iff (!nrst) // [R8]
      $rose(progPulse_ff) |-> ##199 progPulse_ff ##1 !progPulse_ff && cellWord == engData_ff)
      else $error("program pulse length or write wrong");
   AST_READ_PULSE: assert property (@(posedge clk) disable iff (!nrst) // [R9]
      $rose(readPulse_ff) |-> sqReadPulse ##1 readWord_ff == $past(cellWord, 2))
      else $error("read pulse length or readback wrong");
   AST_EXIT_SETTLE: assert property (@(posedge clk) disable iff (!nrst) // [R10]
      sqExitBegin |-> sqPinsHeld)
      else $error("pins handed back too early");
   AST_EXIT_LEN: assert property (@(posedge clk) disable iff (!nrst) // [R10]
      $rose(userReady_ff) |-> phaseLen_ff == (TW+1)'(EXIT_CYC) && !ioProgMode_ff)
      else $error("exit settle time wrong");
   AST_JOB_GATED: assert property (@(posedge clk) disable iff (!nrst) // [R11]
      fifoInValid |-> progReady_ff && state_ff != nvp_pkg::ST_USER)
      else $error("job queued outside programming mode");
endmodule

// >>> test/nvp_prog_model.sv
// Serial programmer model at the far side of the link port
`timescale 1ns/1ns
module nvp_prog_model (
   // Link pins
   output logic tck,
   output logic tsel,
   output logic tdi,
   input wire logic tdoOut,
   input wire logic tdoEn
);
   initial begin
      tck = 1'b0;
      tsel = 1'b0;
      tdi = 1'b0;
   end

   // ----------------------------------------
   // Frame transfer
   // ----------------------------------------
   // Clock runs inside a frame plus one idle edge after it, bits MSB first
   task automatic send(input int len, input logic [31:0] w, output logic [15:0] rd);
      int k;
      rd = 16'h0;
      #7;
      tsel = 1'b1;
      for (k = 0; k < len; k++) begin
         tdi = w[len-1-k];
         #6 tck = 1'b1;
         #6 tck = 1'b0;
         if (k < 16) rd[15-k] = tdoOut;
      end
      tsel = 1'b0;
      // Undriven data line must not keep its last value
      tdi = ~tdi;
      // One idle edge releases the readback driver
      #6 tck = 1'b1;
      #6 tck = 1'b0;
   endtask
endmodule

// >>> test/nvp_program_seq_tb.sv
// Self-checking bench of the nonvolatile programming sequencer
`timescale 1ns/1ns
`include "nvp_map.svh"
module nvp_program_seq_tb;
   localparam int ENTER = 20;
   localparam int EXIT = 20;
   localparam int ERASE = 50;
   logic clk, nrst, tck, tsel, tdi;
   logic tdoOut, tdoEn, ioProgMode, progReady, userReady, seqBusy, frameError;
   logic [15:0] rd;
   logic [7:0] adr [3] = '{8'h00, 8'h10, 8'hff};
   logic [15:0] dat [3] = '{16'h1234, 16'ha5c3, 16'h0001};
   int nFail = 0;
   int comparisons = 0;
   int n;

   nvp_program_seq #(.ENTER_CYC(ENTER), .EXIT_CYC(EXIT), .ERASE_CYC(ERASE)) dut (
      .clk(clk), .nrst(nrst), .tck(tck), .tsel(tsel), .tdi(tdi), .tdoOut(tdoOut),
      .tdoEn(tdoEn), .ioProgMode(ioProgMode), .progReady(progReady),
      .userReady(userReady), .seqBusy(seqBusy), .frameError(frameError));
   nvp_prog_model prg (.tck(tck), .tsel(tsel), .tdi(tdi), .tdoOut(tdoOut), .tdoEn(tdoEn));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         nFail++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, nFail);
      if (nFail == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Frame, then wait until the sequencer is idle again
   task automatic op(input int len, input logic [31:0] w);
      prg.send(len, w, rd);
      repeat (8) @(negedge clk);
      n = 0;
      while (seqBusy !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      check({31'h0, seqBusy}, 32'h0, "idle");
      check({31'h0, tdoEn}, 32'h0, "tdo released");
   endtask

   // Cycles from frame end until a status pin reaches a level
   task automatic timed(input logic [7:0] opc, ref logic pin);
      prg.send(8, {24'h0, opc}, rd);
      n = 0;
      while (pin !== 1'b1 && n < 500) begin
         @(negedge clk);
         n++;
      end
   endtask

   // Read pulse, then a second frame shifts the word out
   task automatic vread(input logic [7:0] a, input logic [15:0] exp);
      op(16, {16'h0, `NVP_OP_VERIFY, a});
      op(16, {16'h0, `NVP_OP_VERIFY, a});
      check({16'h0, rd}, {16'h0, exp}, "readback");
      check({31'h0, frameError}, 32'h0, "verify accepted");
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_refused();
      check({28'h0, ioProgMode, progReady, userReady, seqBusy}, 32'h2, "reset pins");
      op(8, {24'h0, `NVP_OP_ERASE});
      check({31'h0, frameError}, 32'h1, "erase outside mode");
      op(12, 32'h0000_0123);
      check({31'h0, frameError}, 32'h1, "odd length");
   endtask

   task automatic t_enter();
      timed(`NVP_OP_ENTER, progReady);
      check({31'h0, (n >= ENTER && n <= ENTER + 10)}, 32'h1, "enter settle");
      check({30'h0, ioProgMode, userReady}, 32'h2, "pins in mode");
      op(8, {24'h0, `NVP_OP_IDCODE});
      // An 8-bit frame shifts out only half the word, so a 16-bit one reads it
      op(16, {16'h0, `NVP_OP_VERIFY, 8'h00});
      check({16'h0, rd}, {16'h0, `NVP_ID_CODE}, "identity");
   endtask

   task automatic t_erase();
      prg.send(8, {24'h0, `NVP_OP_ERASE}, rd);
      n = 0;
      repeat (200) begin
         @(negedge clk);
         if (seqBusy === 1'b1) n++;
      end
      check({31'h0, (n >= ERASE && n <= ERASE + 10)}, 32'h1, "erase pulse");
      vread(8'h10, `NVP_ERASED);
   endtask

   task automatic t_program();
      for (int i = 0; i < 3; i++) begin
         op(32, {`NVP_OP_PROGRAM, adr[i], dat[i]});
         check({31'h0, frameError}, 32'h0, "program accepted");
      end
      for (int i = 0; i < 3; i++)
         vread(adr[i], dat[i]);
      vread(8'h20, `NVP_ERASED);
   endtask

   task automatic t_exit();
      timed(`NVP_OP_EXIT, userReady);
      check({31'h0, (n >= EXIT && n <= EXIT + 10)}, 32'h1, "exit settle");
      check({30'h0, ioProgMode, progReady}, 32'h0, "pins in user mode");
   endtask

   // Enter, identity, verify, exit: cells kept with no erase
   task automatic t_verify_only();
      t_enter();
      if (rd === `NVP_ID_CODE) begin
         vread(adr[1], dat[1]);
      end
      t_exit();
   endtask

   initial begin
      // Link flops see no clock in reset, so they need a real falling edge
      nrst = 1'b1;
      #1;
      nrst = 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(negedge clk);
      t_refused();
      t_enter();
      t_erase();
      t_program();
      t_exit();
      t_verify_only();
      results();
   end

   // Whole run needs well under a millisecond
   initial begin
      #3000000;
      nFail++;
      results();
   end
endmodule
